// ---- include/bae_consts.vh ----
/*
 * Constants for the byte ALU and branch execution block: opcodes,
 * field positions, flag positions and reset values.
 * Assumes a 14-bit instruction word presented by the decoder.
 */
`ifndef BAE_CONSTS_VH
`define BAE_CONSTS_VH

// Opcode classes on the upper three to six bits of the word
`define BAE_OP_ADD_ACC_TO_FILE   6'h07
`define BAE_OP_AND_ACC_FILE   6'h05
`define BAE_OP_COMPLEMENT_FILE    6'h09
`define BAE_OP_DECREMENT_FILE    6'h03
`define BAE_OP_INCREMENT_FILE    6'h0A
`define BAE_OP_DECREMENT_SKIP_ZERO  6'h0B
`define BAE_OP_INCREMENT_SKIP_ZERO  6'h0F
`define BAE_OP_AND_LITERAL_ACC   6'h39
`define BAE_OP_ADD_LITERAL_TO_ACC_H 5'h1F
`define BAE_OP_BCF     4'h4
`define BAE_OP_BSF     4'h5
`define BAE_OP_JMP     3'h5

// Field positions
`define BAE_DEST_BIT   7
`define BAE_BIT_LSB    7
`define BAE_LATCH_LSB  3

// Status flag positions
`define BAE_FLAG_C     0
`define BAE_FLAG_DC    1
`define BAE_FLAG_Z     2

// Reset values
`define BAE_ACC_RST    8'h00
`define BAE_FLAGS_RST  3'h0
`define BAE_PC_RST     13'h0000

`endif

// ---- test/bae_exec_asserts.sv ----
/* Port checker for bae_exec.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "bae_consts.vh"
module bae_exec_chk #(parameter PC_W = 13) (
    // Inputs and state
    input wire logic            core_clk,
    input wire logic            sys_rst,
    input wire logic            instrValid,
    input wire logic [13:0]     instrWord,
    input wire logic [7:0]      pcHighLatch,
    input wire logic [7:0]      fileRdata,
    input wire logic            fileWe_r,
    input wire logic [6:0]      fileWaddr_r,
    input wire logic [7:0]      fileWdata_r,
    input wire logic [7:0]      acc_r,
    input wire logic            carryFlag_r,
    input wire logic            digitCarryFlag_r,
    input wire logic            zeroFlag_r,
    input wire logic [PC_W-1:0] pc_r,
    input wire logic            slotFlush_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire       go  = instrValid && !slotFlush_r;
    wire [2:0] flg = {carryFlag_r, digitCarryFlag_r, zeroFlag_r};
    a_add_literal: assert property (go && instrWord[13:9] == `BAE_OP_ADD_LITERAL_TO_ACC_H |=>
        {carryFlag_r, acc_r} == $past(acc_r) + $past(instrWord[7:0])) else $error("add sum");
    a_and_literal: assert property (go && instrWord[13:8] == `BAE_OP_AND_LITERAL_ACC |=>
        acc_r == ($past(acc_r) & $past(instrWord[7:0])) && zeroFlag_r == (acc_r == 8'h00))
        else $error("and result");
    a_comp_file: assert property (go && instrWord[13:7] == {`BAE_OP_COMPLEMENT_FILE, 1'b1} |=>
        fileWe_r && fileWdata_r == ~$past(fileRdata)) else $error("complement");
    a_bit_flags: assert property (go && instrWord[13:11] == 3'h2 |=>
        fileWe_r && fileWaddr_r == $past(instrWord[6:0]) && $stable(flg)) else $error("bit op");
    a_skip_taken: assert property (go && instrWord[13:8] == `BAE_OP_INCREMENT_SKIP_ZERO
        && fileRdata == 8'hFF |=> slotFlush_r && $stable(flg)) else $error("skip taken");
    a_skip_kept: assert property (go && instrWord[13:8] == `BAE_OP_DECREMENT_SKIP_ZERO
        && fileRdata != 8'h01 |=> !slotFlush_r) else $error("skip wrongly");
    a_jump_load: assert property (go && instrWord[13:11] == `BAE_OP_JMP |=> slotFlush_r
        && pc_r == {$past(pcHighLatch[4:3]), $past(instrWord[10:0])}) else $error("jump pc");
    a_flush_once: assert property (slotFlush_r |=> !slotFlush_r ##1 1'b1)
        else $error("flush length");
    c_jump: cover property (go && instrWord[13:11] == `BAE_OP_JMP);
    c_flush: cover property (slotFlush_r && instrValid);
    c_write: cover property (fileWe_r);
endmodule
bind bae_exec bae_exec_chk #(.PC_W(PC_W)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .instrValid(instrValid), .instrWord(instrWord), .pcHighLatch(pcHighLatch),
    .fileRdata(fileRdata), .fileWe_r(fileWe_r), .fileWaddr_r(fileWaddr_r),
    .fileWdata_r(fileWdata_r), .acc_r(acc_r), .carryFlag_r(carryFlag_r),
    .digitCarryFlag_r(digitCarryFlag_r), .zeroFlag_r(zeroFlag_r), .pc_r(pc_r),
    .slotFlush_r(slotFlush_r));
`default_nettype wire

// ---- test/bae_file_model.sv ----
/* Data file model: 128 bytes.
   Assumes reads answer the address at once and writes land on the edge. */
`timescale 1ns/1ps
`default_nettype none
module bae_file_model (
    // Clock
    input  wire logic       core_clk,
    // Read and write sides
    input  wire logic [6:0] rdAddr,
    output var  logic [7:0] rdData,
    input  wire logic       wrEn,
    input  wire logic [6:0] wrAddr,
    input  wire logic [7:0] wrData
);
    logic [7:0] mem [0:127];
    assign rdData = mem[rdAddr];
    always @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
/* Testbench for bae_exec with the data file model.
   Assumes one instruction per cycle from the bench. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, sys_rst = 1'b1, instrValid = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic [7:0] pcHighLatch = 8'hE8;
    wire [6:0] fileAddr, fileWaddr_r;
    wire [7:0] fileRdata, fileWdata_r, acc_r;
    wire fileWe_r, carryFlag_r, digitCarryFlag_r, zeroFlag_r, slotFlush_r;
    wire [12:0] pc_r;
    wire [2:0] flg = {carryFlag_r, digitCarryFlag_r, zeroFlag_r};
    int errors = 0, comparisons = 0;
    initial forever #5 core_clk = ~core_clk;
    bae_exec #(.PC_W(13)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .instrValid(instrValid), .instrWord(instrWord), .pcHighLatch(pcHighLatch),
        .fileAddr(fileAddr), .fileRdata(fileRdata), .fileWe_r(fileWe_r),
        .fileWaddr_r(fileWaddr_r), .fileWdata_r(fileWdata_r), .acc_r(acc_r),
        .carryFlag_r(carryFlag_r), .digitCarryFlag_r(digitCarryFlag_r),
        .zeroFlag_r(zeroFlag_r), .pc_r(pc_r), .slotFlush_r(slotFlush_r));
    bae_file_model u_file (.core_clk(core_clk), .rdAddr(fileAddr), .rdData(fileRdata),
        .wrEn(fileWe_r), .wrAddr(fileWaddr_r), .wrData(fileWdata_r));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic put(input logic [13:0] w);
        @(posedge core_clk);
        instrValid <= 1'b1;
        instrWord <= w;
    endtask
    task automatic idle;
        @(posedge core_clk);
        instrValid <= 1'b0;
        // File write is registered; let it land in the model before checking
        @(posedge core_clk);
        #1;
    endtask
    task automatic t_literal;
        put(14'h3EFF); idle; chk("acc", acc_r, 8'hFF); chk("flg", flg, 3'h0);
        put(14'h3E01); idle; chk("acc", acc_r, 8'h00); chk("flg", flg, 3'h7);
        put(14'h3E3C); put(14'h39C3); idle; chk("flg", flg, 3'h1);
        put(14'h3E38); idle; chk("acc", acc_r, 8'h38);
    endtask
    task automatic t_file;
        put(14'h0790); idle; chk("f10", u_file.mem[7'h10], 8'h40); chk("flg", flg, 3'h2);
        put(14'h0510); idle; chk("acc", acc_r, 8'h00); chk("flg", flg, 3'h3);
        put(14'h0991); idle; chk("f11", u_file.mem[7'h11], 8'h00);
        put(14'h0A12); idle; chk("acc", acc_r, 8'h80); chk("flg", flg, 3'h2);
        put(14'h0393); idle; chk("f13", u_file.mem[7'h13], 8'h00); chk("flg", flg, 3'h3);
    endtask
    task automatic t_bits;
        put(14'h1794); put(14'h1015); idle;
        chk("f14", u_file.mem[7'h14], 8'h80); chk("f15", u_file.mem[7'h15], 8'hFE);
        chk("flg", flg, 3'h3);
    endtask
    task automatic t_skip;
        put(14'h0F96); put(14'h3E01); idle; chk("acc", acc_r, 8'h80);
        chk("f16", u_file.mem[7'h16], 8'h00); chk("flg", flg, 3'h3);
        put(14'h0B17); put(14'h3E01); idle; chk("acc", acc_r, 8'h02);
    endtask
    task automatic t_jump;
        put(14'h2DA5); put(14'h3E01); idle; chk("pc", pc_r, 13'h0DA6);
        chk("acc", acc_r, 8'h02);
    endtask
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        u_file.mem[7'h10] = 8'h08; u_file.mem[7'h11] = 8'hFF; u_file.mem[7'h12] = 8'h7F;
        u_file.mem[7'h13] = 8'h01; u_file.mem[7'h14] = 8'h00; u_file.mem[7'h15] = 8'hFF;
        u_file.mem[7'h16] = 8'hFF; u_file.mem[7'h17] = 8'h02;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_literal; t_file; t_bits; t_skip; t_jump;
        conclude;
    end
    // Run needs about 50 cycles; allow far more
    initial begin
        #20000;
        errors++;
        conclude;
    end
endmodule
`default_nettype wire

// ---- verilog/bae_adder.v ----
/*
 * Eight-bit adder with carry and digit carry out.
 * Assumes purely combinational use inside the execution block.
 */
`timescale 1ns/1ps
`default_nettype none
module bae_adder (
    // Operands
    input  wire [7:0] opA,
    input  wire [7:0] opB,
    // Result
    output wire [7:0] sum,
    output wire       carryOut,
    output wire       digitCarry
);
    wire [4:0] lowSum;
    wire [8:0] fullSum;

    assign lowSum     = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    assign fullSum    = {1'b0, opA} + {1'b0, opB};
    assign sum        = fullSum[7:0];
    assign carryOut   = fullSum[8];
    assign digitCarry = lowSum[4];
endmodule
`default_nettype wire

// ---- verilog/bae_exec.v ----
/*
 * Execution datapath for the byte ALU subset and absolute jump.
 * Holds the accumulator, status flags and program counter.
 * Assumes the data file answers a read combinationally at fileAddr and
 * takes a write on the clock edge when fileWe is high; the decoder
 * presents one instruction per cycle with instrValid.
 */
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bae_consts.vh"
module bae_exec #(
    parameter PC_W = 13
) (
    // Clock and reset
    input  wire              core_clk,
    input  wire              sys_rst,
    // Decoder side
    input  wire              instrValid,
    input  wire [13:0]       instrWord,
    input  wire [7:0]        pcHighLatch,
    // Data file side
    output wire [6:0]        fileAddr,
    input  wire [7:0]        fileRdata,
    output reg               fileWe_r,
    output reg  [6:0]        fileWaddr_r,
    output reg  [7:0]        fileWdata_r,
    // Core state
    output reg  [7:0]        acc_r,
    output reg               carryFlag_r,
    output reg               digitCarryFlag_r,
    output reg               zeroFlag_r,
    output reg  [PC_W-1:0]   pc_r,
    output reg               slotFlush_r
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire [5:0] op6   = instrWord[13:8];
    wire       dest  = instrWord[`BAE_DEST_BIT];
    wire [2:0] bitIx = instrWord[9:7];
    wire [7:0] lit   = instrWord[7:0];
    wire       live  = instrValid & ~slotFlush_r;

    assign fileAddr = instrWord[6:0];

    wire isAddLit  = instrWord[13:9] == `BAE_OP_ADD_LITERAL_TO_ACC_H;
    wire isAndLit  = op6 == `BAE_OP_AND_LITERAL_ACC;
    wire isAddFile = op6 == `BAE_OP_ADD_ACC_TO_FILE;
    wire isAndFile = op6 == `BAE_OP_AND_ACC_FILE;
    wire isComp    = op6 == `BAE_OP_COMPLEMENT_FILE;
    wire isDec     = op6 == `BAE_OP_DECREMENT_FILE;
    wire isInc     = op6 == `BAE_OP_INCREMENT_FILE;
    wire isDecSkip = op6 == `BAE_OP_DECREMENT_SKIP_ZERO;
    wire isIncSkip = op6 == `BAE_OP_INCREMENT_SKIP_ZERO;
    wire isBitClr  = instrWord[13:10] == `BAE_OP_BCF;
    wire isBitSet  = instrWord[13:10] == `BAE_OP_BSF;
    wire isJump    = instrWord[13:11] == `BAE_OP_JMP;

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    wire [7:0] addB = isAddLit ? lit : fileRdata;
    wire [7:0] addSum;
    wire       addC;
    wire       addDc;

    bae_adder uAdder (
        .opA        (acc_r),
        .opB        (addB),
        .sum        (addSum),
        .carryOut   (addC),
        .digitCarry (addDc)
    );

    wire [7:0] bitMask = 8'h01 << bitIx;

    // ----------------------------------------------------------------
    // Result select
    // ----------------------------------------------------------------
    reg [7:0] result;
    reg       toFile;
    reg       toAcc;
    reg       setZ;
    reg       setCdc;
    reg       skipReq;
    always @* begin
        result  = 8'h00;
        toFile  = 1'b0;
        toAcc   = 1'b0;
        setZ    = 1'b0;
        setCdc  = 1'b0;
        skipReq = 1'b0;
        if (isAddLit) begin
            result = addSum;
            toAcc  = 1'b1;
            setZ   = 1'b1;
            setCdc = 1'b1;
        end else if (isAndLit) begin
            result = acc_r & lit;
            toAcc  = 1'b1;
            setZ   = 1'b1;
        end else if (isAddFile) begin
            result = addSum;
            setZ   = 1'b1;
            setCdc = 1'b1;
            toAcc  = ~dest;
            toFile = dest;
        end else if (isAndFile) begin
            result = acc_r & fileRdata;
            setZ   = 1'b1;
            toAcc  = ~dest;
            toFile = dest;
        end else if (isComp) begin
            result = ~fileRdata;
            setZ   = 1'b1;
            toAcc  = ~dest;
            toFile = dest;
        end else if (isInc || isDec) begin
            result = isInc ? fileRdata + 8'h01 : fileRdata - 8'h01;
            setZ   = 1'b1;
            toAcc  = ~dest;
            toFile = dest;
        end else if (isIncSkip || isDecSkip) begin
            result  = isIncSkip ? fileRdata + 8'h01 : fileRdata - 8'h01;
            toAcc   = ~dest;
            toFile  = dest;
            skipReq = result == 8'h00;
        end else if (isBitClr) begin
            result = fileRdata & ~bitMask;
            toFile = 1'b1;
        end else if (isBitSet) begin
            result = fileRdata | bitMask;
            toFile = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (sys_rst) begin
            acc_r            <= `BAE_ACC_RST;
            carryFlag_r      <= 1'b0;
            digitCarryFlag_r <= 1'b0;
            zeroFlag_r       <= 1'b0;
            pc_r             <= `BAE_PC_RST;
            slotFlush_r      <= 1'b0;
            fileWe_r         <= 1'b0;
            fileWaddr_r      <= 7'h00;
            fileWdata_r      <= 8'h00;
        end else begin
            fileWe_r    <= 1'b0;
            slotFlush_r <= 1'b0;
            if (live) begin
                if (isJump) begin
                    pc_r <= {pcHighLatch[`BAE_LATCH_LSB+1:`BAE_LATCH_LSB],
                             instrWord[10:0]};
                    slotFlush_r <= 1'b1;
                end else begin
                    pc_r        <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
                    slotFlush_r <= skipReq;
                end
                if (toAcc)
                    acc_r <= result;
                if (toFile) begin
                    fileWe_r    <= 1'b1;
                    fileWaddr_r <= fileAddr;
                    fileWdata_r <= result;
                end
                if (setZ)
                    zeroFlag_r <= result == 8'h00;
                if (setCdc) begin
                    carryFlag_r      <= addC;
                    digitCarryFlag_r <= addDc;
                end
            end else if (instrValid) begin
                pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire
